// >>> inc/tcp_pkg.sv
package tcp_pkg;

    // host port widths
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned CFG_REGS    = 10;

    // register addresses
    localparam logic [3:0] ADDR_CLK_CTL  = 4'h7;
    localparam logic [3:0] ADDR_FMT_CTL  = 4'h8;
    localparam logic [3:0] ADDR_SYS_CTL  = 4'h9;
    localparam logic [3:0] ADDR_ONESHOT  = 4'hA;
    localparam logic [3:0] ADDR_CHKSUM   = 4'hB;
    localparam logic [3:0] ADDR_I_LO     = 4'hC;
    localparam logic [3:0] ADDR_I_HI     = 4'hD;
    localparam logic [3:0] ADDR_Q_LO     = 4'hE;
    localparam logic [3:0] ADDR_Q_HI     = 4'hF;

    // field positions
    localparam int unsigned CLK_LOSS_DIS_BIT = 5;
    localparam int unsigned FMT_REAL_BIT     = 0;
    localparam int unsigned SYS_READY_BIT    = 0;
    localparam int unsigned SYS_MISSED_BIT   = 1;
    localparam int unsigned SYS_SRC_INT_BIT  = 2;
    localparam int unsigned SYS_SS_OFF_BIT   = 3;
    localparam int unsigned SYS_SHORT_BIT    = 4;
    localparam int unsigned SYS_DIAG_BIT     = 5;
    localparam int unsigned SYS_IRQ_EN_BIT   = 6;
    localparam int unsigned SYS_PDOWN_BIT    = 7;

    // reset values
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // sync counter periods
    localparam int unsigned SYNC_CNT_W     = 20;
    localparam logic [19:0] SYNC_LONG_LAST = 20'hFFFFF;
    localparam logic [19:0] SYNC_SHORT_LAST = 20'h000FF;

    // timing
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned LOSS_TIME_MS    = 2;
    localparam int unsigned LOSS_CYCLES     =
        (LOSS_TIME_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int unsigned ONESHOT_TIME_NS = 20;
    localparam int unsigned ONESHOT_CYCLES  =
        (ONESHOT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0]  ONESHOT_LAST    = 4'(ONESHOT_CYCLES - 1);

    // host strobe and address group
    typedef struct packed {
        logic       ce_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] addr;
        logic [7:0] data;
    } tcp_host_s;

    // access state
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } tcp_acc_e;

endpackage

// >>> logic/tcp_port.sv
// What this block does
// - port: 8-bit two-way data, 4-bit address, read, write, chip enable
// - each 8-bit configuration register has its own 4-bit address
// - host reads: address, enable low, read low; device drives register
// - data bus released while enable high or write strobe low
// - read strobe held low selects legacy select plus read/write mode
// - addresses 12-13 give in-phase sample, 14-15 quadrature sample
// - real mode: in-phase holds even samples, quadrature holds odd
// - control register 9 holds sample-ready and sample-missed flags
// - interrupt output signals that a new sample is ready
// - address 11 reads diagnostic checksum values
// - access to address 10 fires one pulse on one-shot output
// - sync strobe comes from external sync input or internal counter
// - internal counter follows external sync unless follow disabled
// - internal counter period is 256 or 2^20 clocks
// - in diagnostics counter clears datapaths and strobes checksum
// - in normal mode counter can resynchronize all chip counters
// - register 7 bit 5 stops loss detect, register 9 bit 7 powers down
// - both low power bits clear at reset
// - clock stopped means static power-down until clock resumes
// - clock stopped beyond 2 ms declares loss, enters power-down
`timescale 1ns/10ps
module tcp_port #(
    parameter int unsigned LOSS_CYCLES = tcp_pkg::LOSS_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    // host port
    input  wire logic        ce_n_in,
    input  wire logic        rd_strobe_n_in,
    input  wire logic        wr_strobe_n_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             data_oe_out,
    output logic             irq_out,
    output logic             oneshot_out_n,
    // sample capture
    input  wire logic        sample_valid_in,
    input  wire logic [15:0] sample_i_in,
    input  wire logic [15:0] sample_q_in,
    input  wire logic [7:0]  checksum_in,
    // sync
    input  wire logic        sys_sync_n_in,
    output logic             sync_strobe_out,
    output logic             datapath_clear_out,
    output logic             checksum_strobe_out,
    // clock monitor and power
    input  wire logic        clk_halt_in,
    output logic             clk_lost_out,
    output logic             power_down_out,
    // configuration to datapaths
    output logic [79:0]      cfg_out
);

    ////////////////////////////////////////////////////////////////////////
    // host pin synchronizers

    tcp_pkg::tcp_host_s host_pin;
    tcp_pkg::tcp_host_s host_s;
    logic               ss_n_s;

    assign host_pin.ce_n = ce_n_in;
    assign host_pin.rd_n = rd_strobe_n_in;
    assign host_pin.wr_n = wr_strobe_n_in;
    assign host_pin.addr = addr_in;
    assign host_pin.data = data_in;

    tcp_sync2 #(
        .W    (15),
        .INIT (15'h7000)
    ) u_host_sync (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .d_in        (host_pin),
        .q_out       (host_s)
    );

    tcp_sync2 #(
        .W    (1),
        .INIT (1'b1)
    ) u_ss_sync (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .d_in        (sys_sync_n_in),
        .q_out       (ss_n_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // access decode

    logic             legacy_r;
    tcp_pkg::tcp_acc_e acc_r;
    tcp_pkg::tcp_acc_e acc_nxt;
    logic [3:0]       acc_addr_r;
    logic [7:0]       wdata_r;
    logic             ss_prev_r;
    logic             wr_fire;
    logic             rd_done;
    logic             ss_fall;

    // mode is picked while the port is idle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            legacy_r <= 1'b0;
        end else if (host_s.ce_n) begin
            legacy_r <= ~host_s.rd_n;
        end
    end

    always_comb begin
        acc_nxt = tcp_pkg::ACC_IDLE;
        if (!host_s.ce_n) begin
            if (legacy_r) begin
                acc_nxt = host_s.wr_n ? tcp_pkg::ACC_READ
                                      : tcp_pkg::ACC_WRITE;
            end else if (!host_s.wr_n && host_s.rd_n) begin
                acc_nxt = tcp_pkg::ACC_WRITE;
            end else if (!host_s.rd_n && host_s.wr_n) begin
                acc_nxt = tcp_pkg::ACC_READ;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_r      <= tcp_pkg::ACC_IDLE;
            acc_addr_r <= 4'h0;
            wdata_r    <= 8'h00;
        end else begin
            acc_r <= acc_nxt;
            if (acc_nxt != tcp_pkg::ACC_IDLE) begin
                acc_addr_r <= host_s.addr;
            end
            if (acc_nxt == tcp_pkg::ACC_WRITE) begin
                wdata_r <= host_s.data;
            end
        end
    end

    // one write per strobe, taken as the strobe goes away
    assign wr_fire = (acc_r == tcp_pkg::ACC_WRITE) &&
                     (acc_nxt != tcp_pkg::ACC_WRITE);
    assign rd_done = (acc_r == tcp_pkg::ACC_READ) &&
                     (acc_nxt != tcp_pkg::ACC_READ);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_prev_r <= 1'b1;
        end else begin
            ss_prev_r <= ss_n_s;
        end
    end

    assign ss_fall = ss_prev_r && !ss_n_s;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0] cfg_r [0:tcp_pkg::CFG_REGS-1];
    logic       ready_r;
    logic       missed_r;

    function automatic logic is_cfg(input logic [3:0] a);
        is_cfg = (a <= tcp_pkg::ADDR_SYS_CTL);
    endfunction

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int k = 0; k < tcp_pkg::CFG_REGS; k++) begin
                cfg_r[k] <= tcp_pkg::CFG_RESET;
            end
        end else if (wr_fire && is_cfg(acc_addr_r)) begin
            cfg_r[acc_addr_r] <= wdata_r;
        end
    end

    always_comb begin
        for (int k = 0; k < tcp_pkg::CFG_REGS; k++) begin
            cfg_out[k*8 +: 8] = cfg_r[k];
        end
    end

    logic clk_loss_dis;
    logic real_mode;
    logic src_int;
    logic ss_off;
    logic short_per;
    logic diag_mode;
    logic irq_en;
    logic force_pd;

    assign clk_loss_dis =
        cfg_r[tcp_pkg::ADDR_CLK_CTL][tcp_pkg::CLK_LOSS_DIS_BIT];
    assign real_mode  = cfg_r[tcp_pkg::ADDR_FMT_CTL][tcp_pkg::FMT_REAL_BIT];
    assign src_int    = cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_SRC_INT_BIT];
    assign ss_off     = cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_SS_OFF_BIT];
    assign short_per  = cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_SHORT_BIT];
    assign diag_mode  = cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_DIAG_BIT];
    assign irq_en     = cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_IRQ_EN_BIT];
    assign force_pd   =
        cfg_r[tcp_pkg::ADDR_SYS_CTL][tcp_pkg::SYS_PDOWN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // sample capture

    logic [15:0] cap_i_r;
    logic [15:0] cap_q_r;
    logic        odd_r;
    logic        pair_done;
    logic        ready_clr;

    // real stream arrives on the in-phase input only
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cap_i_r <= 16'h0000;
            cap_q_r <= 16'h0000;
            odd_r   <= 1'b0;
        end else if (sample_valid_in) begin
            if (!real_mode) begin
                cap_i_r <= sample_i_in;
                cap_q_r <= sample_q_in;
                odd_r   <= 1'b0;
            end else if (!odd_r) begin
                cap_i_r <= sample_i_in;
                odd_r   <= 1'b1;
            end else begin
                cap_q_r <= sample_i_in;
                odd_r   <= 1'b0;
            end
        end
    end

    assign pair_done = sample_valid_in && (!real_mode || odd_r);
    // reading the last quadrature byte hands the sample back
    assign ready_clr = rd_done && (acc_addr_r == tcp_pkg::ADDR_Q_HI);

    // a new sample beats a clear in the same cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ready_r  <= 1'b0;
            missed_r <= 1'b0;
        end else begin
            if (pair_done) begin
                ready_r <= 1'b1;
            end else if (ready_clr) begin
                ready_r <= 1'b0;
            end
            if (pair_done && ready_r && !ready_clr) begin
                missed_r <= 1'b1;
            end else if (wr_fire && acc_addr_r == tcp_pkg::ADDR_SYS_CTL &&
                         !wdata_r[tcp_pkg::SYS_MISSED_BIT]) begin
                missed_r <= 1'b0;
            end
        end
    end

    assign irq_out = ready_r && irq_en;

    ////////////////////////////////////////////////////////////////////////
    // read data path

    function automatic logic [7:0] read_mux(input logic [3:0] a);
        logic [7:0] v;
        v = tcp_pkg::READ_ZERO;
        case (a)
            tcp_pkg::ADDR_SYS_CTL: begin
                v = cfg_r[tcp_pkg::ADDR_SYS_CTL];
                v[tcp_pkg::SYS_READY_BIT]  = ready_r;
                v[tcp_pkg::SYS_MISSED_BIT] = missed_r;
            end
            tcp_pkg::ADDR_ONESHOT: v = tcp_pkg::READ_ZERO;
            tcp_pkg::ADDR_CHKSUM:  v = checksum_in;
            tcp_pkg::ADDR_I_LO:    v = cap_i_r[7:0];
            tcp_pkg::ADDR_I_HI:    v = cap_i_r[15:8];
            tcp_pkg::ADDR_Q_LO:    v = cap_q_r[7:0];
            tcp_pkg::ADDR_Q_HI:    v = cap_q_r[15:8];
            default: begin
                if (is_cfg(a)) begin
                    v = cfg_r[a];
                end
            end
        endcase
        read_mux = v;
    endfunction

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_out <= 8'h00;
        end else begin
            data_out <= read_mux(host_s.addr);
        end
    end

    // drive only during a read; release on enable high or write low
    assign data_oe_out = (acc_r == tcp_pkg::ACC_READ) &&
                         (acc_nxt == tcp_pkg::ACC_READ);

    ////////////////////////////////////////////////////////////////////////
    // one-shot pulse

    logic [3:0] os_cnt_r;
    logic       os_busy_r;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            os_busy_r <= 1'b0;
            os_cnt_r  <= 4'h0;
        end else if ((wr_fire || rd_done) &&
                     acc_addr_r == tcp_pkg::ADDR_ONESHOT) begin
            os_busy_r <= 1'b1;
            os_cnt_r  <= 4'h0;
        end else if (os_busy_r) begin
            if (os_cnt_r == tcp_pkg::ONESHOT_LAST) begin
                os_busy_r <= 1'b0;
            end
            os_cnt_r <= os_cnt_r + 4'h1;
        end
    end

    assign oneshot_out_n = ~os_busy_r;

    ////////////////////////////////////////////////////////////////////////
    // internal sync counter

    logic [19:0] sync_cnt_r;
    logic [19:0] sync_last;
    logic        sync_wrap;
    logic        int_sync_r;

    assign sync_last = short_per ? tcp_pkg::SYNC_SHORT_LAST
                                 : tcp_pkg::SYNC_LONG_LAST;
    assign sync_wrap = (sync_cnt_r >= sync_last);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_cnt_r <= 20'h00000;
            int_sync_r <= 1'b0;
        end else begin
            int_sync_r <= sync_wrap;
            if (ss_fall && !ss_off) begin
                sync_cnt_r <= 20'h00000;
            end else if (sync_wrap) begin
                sync_cnt_r <= 20'h00000;
            end else begin
                sync_cnt_r <= sync_cnt_r + 20'h00001;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_strobe_out     <= 1'b0;
            datapath_clear_out  <= 1'b0;
            checksum_strobe_out <= 1'b0;
        end else begin
            sync_strobe_out     <= src_int ? int_sync_r
                                           : ss_fall;
            datapath_clear_out  <= diag_mode && int_sync_r;
            checksum_strobe_out <= diag_mode && int_sync_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock loss and power-down

    logic [31:0] halt_cnt_r;
    logic        lost_r;

    // the monitor reports a halted clock; loss holds until it resumes
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            halt_cnt_r <= 32'h00000000;
            lost_r     <= 1'b0;
        end else if (!clk_halt_in || clk_loss_dis) begin
            halt_cnt_r <= 32'h00000000;
            lost_r     <= 1'b0;
        end else if (halt_cnt_r > 32'(LOSS_CYCLES)) begin
            lost_r     <= 1'b1;
        end else begin
            halt_cnt_r <= halt_cnt_r + 32'h00000001;
        end
    end

    assign clk_lost_out   = lost_r;
    assign power_down_out = force_pd || lost_r;

endmodule // tcp_port

// >>> logic/tcp_sync2.sv
`timescale 1ns/10ps
module tcp_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         arst_n_in,
    // level in and out
    input  wire logic [W-1:0] d_in,
    output logic [W-1:0]      q_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= INIT;
            hold_r <= INIT;
        end else begin
            meta_r <= d_in;
            hold_r <= meta_r;
        end
    end

    assign q_out = hold_r;

endmodule // tcp_sync2

// >>> testbench/tcp_host_model.sv
`timescale 1ns/10ps
module tcp_host_model (
    // clock
    input  wire logic       core_clk_in,
    // device drive of the data bus
    input  wire logic [7:0] data_out_in,
    input  wire logic       data_oe_in,
    // host strobes, address and resolved bus
    output logic            ce_n_out,
    output logic            rd_strobe_n_out,
    output logic            wr_strobe_n_out,
    output logic [3:0]      addr_out,
    output logic [7:0]      bus_out
);
    logic       legacy_r;
    logic       drv_r;
    logic [7:0] wdat_r;
    logic [7:0] float_r = 8'h5A;
    int         width_r;

    initial begin
        ce_n_out        = 1'b1;
        rd_strobe_n_out = 1'b1;
        wr_strobe_n_out = 1'b1;
        addr_out        = 4'h0;
        legacy_r        = 1'b0;
        drv_r           = 1'b0;
        wdat_r          = 8'h00;
        width_r         = 5;
    end

    // undriven bus shows a pattern that changes every cycle
    assign bus_out = data_oe_in ? data_out_in
                                : (drv_r ? wdat_r : float_r);
    always @(posedge core_clk_in) float_r <= ~float_r;

    ////////////////////////////////////////////////////////////////////////
    // read strobe held low selects select plus read/write level
    task automatic mode(input logic leg);
        @(posedge core_clk_in);
        legacy_r = leg;
        rd_strobe_n_out <= ~leg;
        repeat (4) @(posedge core_clk_in);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        wdat_r <= d;
        drv_r <= 1'b1;
        ce_n_out <= 1'b0;
        wr_strobe_n_out <= 1'b0;
        repeat (width_r) @(posedge core_clk_in);
        if (legacy_r) ce_n_out <= 1'b1;
        else wr_strobe_n_out <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        ce_n_out <= 1'b1;
        wr_strobe_n_out <= 1'b1;
        drv_r <= 1'b0;
        repeat (3) @(posedge core_clk_in);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge core_clk_in);
        addr_out <= a;
        ce_n_out <= 1'b0;
        rd_strobe_n_out <= 1'b0;
        repeat (width_r) @(posedge core_clk_in);
        q = bus_out;
        ce_n_out <= 1'b1;
        rd_strobe_n_out <= ~legacy_r;
        repeat (3) @(posedge core_clk_in);
    endtask
endmodule // tcp_host_model

// >>> testbench/tcp_port_chk.sv
`timescale 1ns/10ps
module tcp_port_chk #(
    parameter int unsigned LOSS_CYCLES = tcp_pkg::LOSS_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    // host and monitor inputs
    input  wire logic        ce_n_in,
    input  wire logic        rd_strobe_n_in,
    input  wire logic        wr_strobe_n_in,
    input  wire logic        sys_sync_n_in,
    input  wire logic        clk_halt_in,
    // outputs watched
    input  wire logic        data_oe_out,
    input  wire logic        oneshot_out_n,
    input  wire logic        sync_strobe_out,
    input  wire logic        datapath_clear_out,
    input  wire logic        checksum_strobe_out,
    input  wire logic        clk_lost_out,
    input  wire logic        power_down_out,
    input  wire logic [79:0] cfg_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [31:0] halt_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // length of the current clock halt
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            halt_cnt_r <= 32'h0;
        end else begin
            halt_cnt_r <= clk_halt_in ? halt_cnt_r + 32'h1 : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_idle_off;
        ce_n_in [*4] |-> !data_oe_out;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("bus driven while deselected");
    property p_rd_drive;
        $rose(!ce_n_in && !rd_strobe_n_in && wr_strobe_n_in)
            |-> ##3 data_oe_out;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read data not driven");
    property p_wr_once;
        (!ce_n_in && !wr_strobe_n_in && rd_strobe_n_in) [*4]
            |-> $stable(cfg_out[71:0]);
    endproperty
    a_wr_once: assert property (p_wr_once)
        else $error("register changed before strobe end");
    property p_os_pulse;
        $fell(oneshot_out_n) |-> !oneshot_out_n [*4] ##1 oneshot_out_n;
    endproperty
    a_os_pulse: assert property (p_os_pulse)
        else $error("one-shot width wrong");
    property p_pdown;
        power_down_out == (cfg_out[79] || clk_lost_out);
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("power-down level wrong");
    property p_loss_set;
        halt_cnt_r == LOSS_CYCLES + 8 && !cfg_out[61] |-> clk_lost_out;
    endproperty
    a_loss_set: assert property (p_loss_set)
        else $error("clock loss not flagged");
    property p_ss_src;
        $fell(sys_sync_n_in) && !cfg_out[74] |-> ##[1:4] sync_strobe_out;
    endproperty
    a_ss_src: assert property (p_ss_src)
        else $error("external sync not passed on");
    property p_diag;
        datapath_clear_out |-> checksum_strobe_out && cfg_out[77];
    endproperty
    a_diag: assert property (p_diag)
        else $error("clear without diagnostics strobe");
endmodule // tcp_port_chk

bind tcp_port tcp_port_chk #(
    .LOSS_CYCLES(LOSS_CYCLES)
) tcp_port_chk_inst (.*);

// >>> testbench/tcp_port_tb_top.sv
`timescale 1ns/10ps
module tcp_port_tb_top;
    // design pins
    logic        core_clk_in, arst_n_in, ce_n_in, rd_strobe_n_in;
    logic        wr_strobe_n_in, data_oe_out, irq_out, oneshot_out_n;
    logic        sample_valid_in, sys_sync_n_in, sync_strobe_out;
    logic        datapath_clear_out, checksum_strobe_out, clk_halt_in;
    logic        clk_lost_out, power_down_out;
    logic [3:0]  addr_in;
    logic [7:0]  data_in, data_out, checksum_in;
    logic [15:0] sample_i_in, sample_q_in;
    logic [79:0] cfg_out;
    // bookkeeping
    int          mismatches, tests_run, cycles, n_os, n_sync, n;
    logic        os_d;

    tcp_port #(
        .LOSS_CYCLES(20)
    ) tcp_port_inst (.*);

    tcp_host_model tcp_host_model_inst (
        .core_clk_in    (core_clk_in),
        .data_out_in    (data_out),
        .data_oe_in     (data_oe_out),
        .ce_n_out       (ce_n_in),
        .rd_strobe_n_out(rd_strobe_n_in),
        .wr_strobe_n_out(wr_strobe_n_in),
        .addr_out       (addr_in),
        .bus_out        (data_in)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in) begin
        cycles++;
        n_os += int'(os_d && !oneshot_out_n);
        n_sync += int'(sync_strobe_out === 1'b1);
        os_d = oneshot_out_n;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        tcp_host_model_inst.rd(a, q);
        chk({8'h00, q}, {8'h00, e});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        tcp_host_model_inst.wr(a, d);
    endtask

    task automatic smp(input logic [15:0] i, input logic [15:0] qv);
        @(posedge core_clk_in);
        sample_valid_in <= 1'b1;
        sample_i_in <= i;
        sample_q_in <= qv;
        @(posedge core_clk_in);
        sample_valid_in <= 1'b0;
    endtask

    task automatic sync_gap(output int k);
        int s;
        s = n_sync;
        k = 0;
        while (n_sync == s && k < 600) begin
            @(negedge core_clk_in);
            k++;
        end
    endtask

    // external sync held low across one measured gap
    task automatic ss_gap(output int k);
        @(posedge core_clk_in);
        sys_sync_n_in <= 1'b0;
        sync_gap(k);
        @(posedge core_clk_in);
        sys_sync_n_in <= 1'b1;
    endtask

    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n_in = 1'b0;
        sample_valid_in = 1'b0;
        sample_i_in = 16'h0000;
        sample_q_in = 16'h0000;
        checksum_in = 8'hC6;
        sys_sync_n_in = 1'b1;
        clk_halt_in = 1'b0;
        {mismatches, tests_run, cycles, n_os, n_sync} = '0;
        os_d = 1'b1;
        repeat (2) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        rdc(4'h7, 8'h00);
        rdc(4'h9, 8'h00);
        for (int i = 0; i < 9; i++) begin
            tcp_host_model_inst.width_r = 5 + 4 * (i % 2);
            wr(4'(i), 8'h50 | 8'(i));
            rdc(4'(i), 8'h50 | 8'(i));
            chk({8'h00, cfg_out[8*i +: 8]}, 16'h0050 | 16'(i));
        end
        n = n_os;
        rdc(4'hA, 8'h00);
        wr(4'hA, 8'hFF);
        repeat (4) @(posedge core_clk_in);
        chk(16'(n_os - n), 16'h0002);
        wr(4'hB, 8'h11);
        rdc(4'hB, 8'hC6);
        tcp_host_model_inst.mode(1'b1);
        wr(4'h3, 8'hC3);
        rdc(4'h3, 8'hC3);
        tcp_host_model_inst.mode(1'b0);
        wr(4'h9, 8'h40);
        smp(16'h1234, 16'hABCD);
        repeat (3) @(posedge core_clk_in);
        chk({15'h0000, irq_out}, 16'h0001);
        rdc(4'h9, 8'h41);
        rdc(4'hC, 8'h34);
        rdc(4'hD, 8'h12);
        rdc(4'hE, 8'hCD);
        rdc(4'hF, 8'hAB);
        rdc(4'h9, 8'h40);
        smp(16'h0001, 16'h0002);
        smp(16'h0003, 16'h0004);
        rdc(4'h9, 8'h43);
        wr(4'h9, 8'h40);
        rdc(4'h9, 8'h41);
        rdc(4'hF, 8'h00);
        wr(4'h8, 8'h01);
        smp(16'h1111, 16'h0000);
        smp(16'h2222, 16'h0000);
        rdc(4'hC, 8'h11);
        rdc(4'hE, 8'h22);
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h34);
        sync_gap(n);
        sync_gap(n);
        chk(16'(n), 16'h0100);
        wr(4'h9, 8'h1C);
        sync_gap(n);
        ss_gap(n);
        chk(16'(n), 16'h0100);
        wr(4'h9, 8'h14);
        sync_gap(n);
        ss_gap(n);
        chk(16'(n > 256), 16'h0001);
        wr(4'h9, 8'h00);
        n = n_sync;
        sys_sync_n_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        sys_sync_n_in <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        chk(16'(n_sync - n), 16'h0001);
        wr(4'h9, 8'h80);
        chk({15'h0000, power_down_out}, 16'h0001);
        wr(4'h9, 8'h00);
        clk_halt_in <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        chk({15'h0000, clk_lost_out}, 16'h0001);
        clk_halt_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        chk({15'h0000, power_down_out}, 16'h0000);
        wr(4'h7, 8'h20);
        clk_halt_in <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        chk({15'h0000, clk_lost_out}, 16'h0000);
        final_report();
    end
endmodule // tcp_port_tb_top
